// ---- logic/dacs_ctrl_status.sv ----
`timescale 1ns/1ps
`include "dacs_regs.svh"
// Contract
// - Program buffer size field reads zero
// - Bit 12 shows command executing
// - Busy set on command write, cleared on completion
// - Three-bit failure code, resets to zero
// - Status, command or auto-exec write, or data access, while busy records code 1
// - Unsupported command records code 2
// - Execution fault records code 3
// - Wrong hart state records code 4
// - System bus error records code 5
// - Size or alignment records code 7; never 6
// - Code cleared only by writing 111
// - No command starts while code non-zero
// - Data count field reads two
// - Status write while busy sets busy code
// - Command writes ignored while code non-zero
module dacs_ctrl_status (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire dacs_pkg::dacs_dmi_req_t i_dmi,
   input wire dacs_pkg::dacs_cmd_result_t i_result,
   output logic [31:0] o_rdata,
   output logic o_cmd_start,
   output logic o_busy,
   output logic [2:0] o_err
);
   import dacs_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam logic [4:0] PROGBUF_SIZE = `DACS_PROGBUF_SIZE;
   localparam logic [3:0] DATA_COUNT = `DACS_DATA_COUNT;

   logic busy;
   logic next_busy;
   logic [2:0] err;
   logic [2:0] next_err;
   logic [31:0] next_rdata;
   logic [31:0] status_word;
   dacs_err_t exec_code;
   logic sel_cs;
   logic sel_cmd;
   logic sel_auto;
   logic sel_data;
   logic wr_cs;
   logic rd_cs;
   logic wr_cmd;
   logic wr_auto;
   logic acc_data;
   logic busy_hit;
   logic err_clear;
   logic err_empty;
   logic exec_fail;

   // ************************************************************
   // Address decode
   // ************************************************************
   always_comb begin
      sel_cs = 1'b0;
      sel_cmd = 1'b0;
      sel_auto = 1'b0;
      sel_data = 1'b0;
      case (i_dmi.addr)
         `DACS_IDX_CTRL_STATUS: begin
            sel_cs = 1'b1;
         end
         `DACS_IDX_COMMAND: begin
            sel_cmd = 1'b1;
         end
         `DACS_IDX_AUTO_EXEC: begin
            sel_auto = 1'b1;
         end
         `DACS_IDX_FIRST_DATA, `DACS_IDX_SECOND_DATA: begin
            sel_data = 1'b1;
         end
         default: begin
            sel_cs = 1'b0;
         end
      endcase
   end

   assign wr_cs = i_dmi.wr && sel_cs;
   assign rd_cs = i_dmi.rd && sel_cs;
   assign wr_cmd = i_dmi.wr && sel_cmd;
   assign wr_auto = i_dmi.wr && sel_auto;
   // Data reads count too: mid-command results would be stale
   assign acc_data = (i_dmi.wr || i_dmi.rd) && sel_data;
   assign busy_hit = busy && (wr_cs || wr_cmd || wr_auto || acc_data);
   // Only the full all-ones pattern clears, partial patterns keep the error
   assign err_clear = wr_cs &&
      (i_dmi.wdata[`DACS_ERR_MSB:`DACS_ERR_LSB] == `DACS_ERR_CLEAR_ALL);
   assign err_empty = (err == `DACS_ERR_RESET);
   assign exec_fail = busy && (exec_code != DACS_ERR_NONE);

   // ************************************************************
   // Command start gate
   // ************************************************************
   // Start only when idle and error-free; late command writes just flag busy
   assign o_cmd_start = wr_cmd && !busy && err_empty;

   dacs_err_select u_err_select (
      .i_result(i_result),
      .o_code(exec_code)
   );

   // ************************************************************
   // Status word
   // ************************************************************
   // Per-bit loop keeps every reserved bit tied to zero
   for (genvar b = 0; b < 32; b++) begin : g_status_bit
      if ((b >= `DACS_PROGBUF_LSB) && (b <= `DACS_PROGBUF_MSB)) begin : g_progbuf
         assign status_word[b] = PROGBUF_SIZE[b - `DACS_PROGBUF_LSB];
      end else if (b == `DACS_BUSY_BIT) begin : g_busy
         assign status_word[b] = busy;
      end else if ((b >= `DACS_ERR_LSB) && (b <= `DACS_ERR_MSB)) begin : g_err
         assign status_word[b] = err[b - `DACS_ERR_LSB];
      end else if ((b >= `DACS_DCOUNT_LSB) && (b <= `DACS_DCOUNT_MSB)) begin : g_dcount
         assign status_word[b] = DATA_COUNT[b - `DACS_DCOUNT_LSB];
      end else begin : g_reserved
         assign status_word[b] = 1'b0;
      end
   end

   // ************************************************************
   // Activity bit
   // ************************************************************
   always_comb begin
      next_busy = busy;
      if (o_cmd_start) begin
         next_busy = 1'b1;
      end else if (i_result.done) begin
         next_busy = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= next_busy;
      end
   end

   // ************************************************************
   // Failure code
   // ************************************************************
   always_comb begin
      next_err = err;
      if (err_clear) begin
         next_err = `DACS_ERR_RESET;
      end
      // New errors load only into a field that is already empty; a same-cycle clear of a non-zero field wins and drops them
      if (err_empty) begin
         if (busy_hit) begin
            next_err = DACS_ERR_BUSY;
         end else if (exec_fail) begin
            next_err = exec_code;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         err <= `DACS_ERR_RESET;
      end else begin
         err <= next_err;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   // Other words read zero here; their owners answer elsewhere
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_cs) begin
         next_rdata = status_word;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_busy = busy;
   assign o_err = err;
endmodule

// ---- logic/dacs_regs.svh ----
`ifndef DACS_REGS_SVH
`define DACS_REGS_SVH
// ************************************************************
// Debug module word indices and field layout
// ************************************************************
`define DACS_ADDR_W 7
`define DACS_IDX_CTRL_STATUS 7'h16
`define DACS_IDX_COMMAND 7'h17
`define DACS_IDX_FIRST_DATA 7'h04
`define DACS_IDX_SECOND_DATA 7'h05
`define DACS_IDX_AUTO_EXEC 7'h18
`define DACS_PROGBUF_MSB 28
`define DACS_PROGBUF_LSB 24
`define DACS_BUSY_BIT 12
`define DACS_ERR_MSB 10
`define DACS_ERR_LSB 8
`define DACS_DCOUNT_MSB 3
`define DACS_DCOUNT_LSB 0
`define DACS_PROGBUF_SIZE 5'h00
`define DACS_DATA_COUNT 4'h2
`define DACS_ERR_RESET 3'h0
`define DACS_ERR_CLEAR_ALL 3'h7
`endif

// ---- logic/dacs_pkg.sv ----
package dacs_pkg;
   typedef enum logic [2:0] {
      DACS_ERR_NONE = 3'h0,
      DACS_ERR_BUSY = 3'h1,
      DACS_ERR_NOT_SUPPORTED = 3'h2,
      DACS_ERR_EXCEPTION = 3'h3,
      DACS_ERR_HALT_RESUME = 3'h4,
      DACS_ERR_BUS = 3'h5,
      DACS_ERR_RESERVED = 3'h6,
      DACS_ERR_OTHER = 3'h7
   } dacs_err_t;

   // Register access from the debug module interface
   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] addr;
      logic [31:0] wdata;
   } dacs_dmi_req_t;

   // Completion report from the command executor
   typedef struct packed {
      logic done;
      logic unsupported;
      logic exception;
      logic halt_state;
      logic bus_error;
      logic size_align;
   } dacs_cmd_result_t;
endpackage

// ---- logic/dacs_err_select.sv ----
`timescale 1ns/1ps
module dacs_err_select (
   input wire dacs_pkg::dacs_cmd_result_t i_result,
   output dacs_pkg::dacs_err_t o_code
);
   import dacs_pkg::*;

   // Fixed priority when several failure causes coincide; code 6 never chosen
   always_comb begin
      o_code = DACS_ERR_NONE;
      if (i_result.done) begin
         if (i_result.unsupported) begin
            o_code = DACS_ERR_NOT_SUPPORTED;
         end else if (i_result.halt_state) begin
            o_code = DACS_ERR_HALT_RESUME;
         end else if (i_result.size_align) begin
            o_code = DACS_ERR_OTHER;
         end else if (i_result.exception) begin
            o_code = DACS_ERR_EXCEPTION;
         end else if (i_result.bus_error) begin
            o_code = DACS_ERR_BUS;
         end
      end
   end
endmodule

// ---- sim/dacs_ctrl_status_monitor.sv ----
`timescale 1ns/1ps
module dacs_ctrl_status_monitor (
   input logic i_sys_clk,
   input logic i_rst_n,
   input dacs_pkg::dacs_dmi_req_t i_dmi,
   input dacs_pkg::dacs_cmd_result_t i_result,
   input logic [31:0] o_rdata,
   input logic o_cmd_start,
   input logic o_busy,
   input logic [2:0] o_err
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   wire a16 = i_dmi.addr == 7'h16;
   wire clr = i_dmi.wr && a16 && i_dmi.wdata[10:8] == 3'h7;
   wire hit = i_dmi.wr && i_dmi.addr inside {7'h16, 7'h17, 7'h18, 7'h04, 7'h05};
   a_start_busy: assert property (o_cmd_start |=> o_busy)
      else $error("busy not set");
   a_done_idle: assert property (i_result.done && o_busy |=> !o_busy)
      else $error("busy not cleared");
   a_start_gate: assert property (o_cmd_start |-> !o_busy && o_err == 3'h0)
      else $error("start not refused");
   a_busy_hit: assert property (o_busy && hit && o_err == 3'h0 && !i_result.done
      |=> o_err == 3'h1) else $error("busy code missing");
   a_err_hold: assert property (o_err != 3'h0 && !clr |=> $stable(o_err))
      else $error("code changed");
   a_err_clear: assert property (clr && !o_busy |=> o_err == 3'h0)
      else $error("code not cleared");
   a_no_six: assert property (o_err != 3'h6)
      else $error("reserved code");
   a_bus_code: assert property (o_busy && i_result == 6'h22 && o_err == 3'h0 &&
      !i_dmi.wr && !i_dmi.rd
      |=> o_err == 3'h5) else $error("bus code missing");
   a_csr_word: assert property (i_dmi.rd && a16 |=> (o_rdata & 32'hffffe8ff) == 32'h2)
      else $error("fixed fields wrong");
   c_start: cover property (o_cmd_start);
   c_bus: cover property (o_err == 3'h5);
   c_clear: cover property (clr && o_err != 3'h0);
endmodule

// ---- sim/dacs_dbg_model.sv ----
`timescale 1ns/1ps
module dacs_dbg_model (
   input logic i_sys_clk,
   input logic [31:0] i_rdata,
   output dacs_pkg::dacs_dmi_req_t o_dmi
);
   initial o_dmi = '0;
   task automatic acc(input logic r, input logic w, input logic [6:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      o_dmi <= {r, w, a, d};
      @(posedge i_sys_clk);
      o_dmi <= '0;
      #1;
   endtask
   // Code is stale while busy, so poll first
   task automatic status(output logic [31:0] v);
      do acc(1'b1, 1'b0, 7'h16, '0);
      while (i_rdata[12]);
      v = i_rdata;
   endtask
endmodule

// ---- sim/debug_abstract_cmd_status_bench.sv ----
`timescale 1ns/1ps
module debug_abstract_cmd_status_bench;
   import dacs_pkg::*;
   logic i_sys_clk = 0;
   logic i_rst_n = 0;
   dacs_dmi_req_t i_dmi;
   dacs_cmd_result_t res = '0;
   logic [31:0] o_rdata, v;
   logic o_cmd_start, o_busy;
   logic [2:0] o_err;
   logic [4:0] flg = '0;
   int cnt = 0, cyc = 0, n_errors = 0, num_checks = 0;
   dacs_ctrl_status uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_dmi(i_dmi),
      .i_result(res), .o_rdata(o_rdata), .o_cmd_start(o_cmd_start), .o_busy(o_busy),
      .o_err(o_err));
   dacs_dbg_model d (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata), .o_dmi(i_dmi));
   initial forever #5 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      res <= '0;
      if (o_cmd_start) cnt <= 4;
      else if (cnt != 0) cnt <= cnt - 1;
      if (cnt == 1) res <= {1'b1, flg};
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         finish_test;
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_reset;
      d.status(v);
      check(v, 32'h2);
   endtask
   task automatic t_codes;
      logic [4:0] f [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
      logic [2:0] e [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h0};
      for (int i = 0; i < 6; i++) begin
         flg = f[i];
         d.acc(1'b0, 1'b1, 7'h17, '0);
         d.status(v);
         check(v, {21'h0, e[i], 8'h02});
         d.acc(1'b0, 1'b1, 7'h16, 32'h700);
         d.status(v);
         check(v, 32'h2);
      end
   endtask
   task automatic t_busy;
      logic [6:0] a [5] = '{7'h17, 7'h16, 7'h18, 7'h04, 7'h05};
      flg = '0;
      for (int i = 0; i < 5; i++) begin
         d.acc(1'b0, 1'b1, 7'h17, '0);
         d.acc(1'b0, 1'b1, a[i], '0);
         d.status(v);
         check(v, 32'h102);
         d.acc(1'b0, 1'b1, 7'h17, '0);
         check({31'h0, o_busy}, 32'h0);
         d.acc(1'b0, 1'b1, 7'h16, 32'h300);
         d.status(v);
         check(v, 32'h102);
         d.acc(1'b0, 1'b1, 7'h16, 32'h700);
      end
   endtask
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      t_reset;
      t_codes;
      t_busy;
      finish_test;
   end
endmodule
bind dacs_ctrl_status dacs_ctrl_status_monitor mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_dmi(i_dmi), .i_result(i_result), .o_rdata(o_rdata), .o_cmd_start(o_cmd_start),
   .o_busy(o_busy), .o_err(o_err));
